// ### afc_buf.v
// afc_buf.v: small synchronous buffer with valid/ready on both sides
// assumes: single clock, async active-low reset, DEPTH a power of two
module afc_buf #(
  parameter W     = 9,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire          sys_clk,
  input  wire          rst_n,
  input  wire          in_valid,
  output reg           in_ready,
  input  wire [W-1:0]  in_data,
  output reg           out_valid,
  input  wire          out_ready,
  output wire [W-1:0]  out_data
);

  reg [W-1:0]  mem [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0]   cnt_r;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;
  wire [AW:0] cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign out_data = mem[rp_r];

  // ----------------------------------------------------------------
  // storage, no reset needed
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  // ----------------------------------------------------------------
  // pointers and registered flags
  // ----------------------------------------------------------------
  // flags come from the next count so ready drops the cycle it fills
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r      <= {AW{1'b0}};
      rp_r      <= {AW{1'b0}};
      cnt_r     <= {(AW+1){1'b0}};
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r     <= cnt_nxt;
      in_ready  <= (cnt_nxt != DEPTH[AW:0]);
      out_valid <= (cnt_nxt != {(AW+1){1'b0}});
    end
  end

endmodule // afc_buf

// ### afc_ctrl.v
// afc_ctrl.v: host controller driving one or more strobe-driven queues
// assumes: device pins wired straight out; flags and out_bus are async
`include "afc_map.vh"
module afc_ctrl #(
  parameter DW   = 9,
  parameter NDEV = 1
) (
  input  wire             sys_clk,
  input  wire             rst_n,
  // user write side
  input  wire             wr_valid,
  output wire             wr_ready,
  input  wire [DW-1:0]    wr_data,
  // user read side
  output reg              rd_valid,
  input  wire             rd_ready,
  output reg  [DW-1:0]    rd_data,
  // user control
  input  wire             init_req,
  input  wire             rewind_req,
  input  wire             depth_mode,
  output reg              busy,
  output reg              dev_full,
  output reg              dev_empty,
  output reg              half_full,
  // device pins
  output reg              put_strobe_n,
  output reg              take_pulse_n,
  output reg              init_n,
  output reg  [NDEV-1:0]  first_rewind_n,
  output reg              expansion_in_n,
  output reg  [DW-1:0]    in_bus,
  input  wire [DW-1:0]    out_bus,
  input  wire [NDEV-1:0]  no_room_flag_n,
  input  wire [NDEV-1:0]  no_data_flag_n,
  input  wire             midpoint_flag_n
);

  // ----------------------------------------------------------------
  // cycle counts derived from the ns figures
  // ----------------------------------------------------------------
  localparam integer CLK = `AFC_T_CLK_NS;
  localparam integer WPW = (`AFC_T_WPW_NS > `AFC_T_SETUP_NS) ?
                           `AFC_T_WPW_NS : `AFC_T_SETUP_NS;
  localparam integer RPW = (`AFC_T_RPW_NS > `AFC_T_ACC_NS) ?
                           `AFC_T_RPW_NS : `AFC_T_ACC_NS;
  localparam integer WLO_I = (WPW + CLK - 1) / CLK;
  // read low also covers the data bus synchroniser
  localparam integer RLO_I = (RPW + CLK - 1) / CLK + `AFC_SYNC_CYC;
  localparam integer RST_I = (`AFC_T_RST_NS + CLK - 1) / CLK;
  localparam integer RET_I = (`AFC_T_RET_NS + CLK - 1) / CLK;
  // flag delay plus synchroniser before flags are trusted again
  localparam integer SET_I = (`AFC_T_FLAG_NS + CLK - 1) / CLK + `AFC_SYNC_CYC;
  // counts fit the 8-bit down counter, cut on purpose
  localparam [7:0] WLO_CYC = WLO_I[7:0];
  localparam [7:0] RLO_CYC = RLO_I[7:0];
  localparam [7:0] RST_CYC = RST_I[7:0];
  localparam [7:0] RET_CYC = RET_I[7:0];
  localparam [7:0] SET_CYC = SET_I[7:0];

  // ----------------------------------------------------------------
  // lead-device pattern: device 0 low, the rest high
  // ----------------------------------------------------------------
  wire [NDEV-1:0] lead_pat;
  genvar g;
  generate
    for (g = 0; g < NDEV; g = g + 1) begin : g_lead
      assign lead_pat[g] = (g != 0);
    end
  endgenerate

  // ----------------------------------------------------------------
  // pin synchronisers, two stages each
  // ----------------------------------------------------------------
  reg [NDEV-1:0] room_s1_r, room_s2_r;
  reg [NDEV-1:0] data_s1_r, data_s2_r;
  reg            mid_s1_r, mid_s2_r;
  reg [DW-1:0]   out_s1_r, out_s2_r;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // idle level of the full flag, so no false full follows reset
      room_s1_r <= {NDEV{1'b1}};
      room_s2_r <= {NDEV{1'b1}};
      data_s1_r <= {NDEV{1'b0}};
      data_s2_r <= {NDEV{1'b0}};
      mid_s1_r  <= 1'b1;
      mid_s2_r  <= 1'b1;
      out_s1_r  <= {DW{1'b0}};
      out_s2_r  <= {DW{1'b0}};
    end else begin
      room_s1_r <= no_room_flag_n;
      room_s2_r <= room_s1_r;
      data_s1_r <= no_data_flag_n;
      data_s2_r <= data_s1_r;
      mid_s1_r  <= midpoint_flag_n;
      mid_s2_r  <= mid_s1_r;
      out_s1_r  <= out_bus;
      out_s2_r  <= out_s1_r;
    end
  end

  // composite flags: any device with room / with data
  wire comp_room = |room_s2_r;
  wire comp_data = |data_s2_r;

  // ----------------------------------------------------------------
  // data buffer between user and device writes
  // ----------------------------------------------------------------
  wire          buf_ov;
  wire [DW-1:0] buf_data;
  reg           pop_r;

  afc_buf #(
    .W     (DW),
    .DEPTH (`AFC_BUF_DEPTH),
    .AW    (`AFC_BUF_AW)
  ) u_buf (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (buf_ov),
    .out_ready (pop_r),
    .out_data  (buf_data)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  reg [2:0] state_r;
  reg [7:0] cnt_r;
  reg       mode_r;
  reg       last_rd_r;
  reg       init_pend_r;
  reg       rew_pend_r;

  // a write waits for the room flag and a word; the pop is one cycle
  wire can_wr = comp_room & buf_ov & ~pop_r;
  wire can_rd = comp_data & ~rd_valid;
  wire go_rd  = can_rd & (~can_wr | ~last_rd_r);
  wire take_i = (state_r == `AFC_ST_IDLE) & ~init_pend_r;
  wire take_rw = take_i & rew_pend_r & ~mode_r;

  // pending requests: a new request beats the clear in the same cycle
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_pend_r <= 1'b0;
      rew_pend_r  <= 1'b0;
    end else begin
      init_pend_r <= init_req | (init_pend_r & (state_r != `AFC_ST_IDLE));
      // rewind is dropped in depth mode, where the pin is a strap
      rew_pend_r  <= rewind_req | (rew_pend_r & ~take_rw & ~(take_i & mode_r));
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r        <= `AFC_ST_RST;
      cnt_r          <= RST_CYC - 8'h01;
      mode_r         <= 1'b0;
      last_rd_r      <= 1'b0;
      pop_r          <= 1'b0;
      put_strobe_n   <= 1'b1;
      take_pulse_n   <= 1'b1;
      init_n         <= 1'b0;
      first_rewind_n <= {NDEV{1'b1}};
      expansion_in_n <= 1'b0;
      in_bus         <= {DW{1'b0}};
      rd_valid       <= 1'b0;
      rd_data        <= {DW{1'b0}};
      busy           <= 1'b1;
      dev_full       <= 1'b0;
      dev_empty      <= 1'b1;
      half_full      <= 1'b0;
    end else begin
      pop_r     <= 1'b0;
      busy      <= (state_r != `AFC_ST_IDLE);
      dev_full  <= ~comp_room;
      dev_empty <= ~comp_data;
      // midpoint only means something standalone
      half_full <= ~mode_r & ~mid_s2_r;
      if (rd_valid && rd_ready) begin
        rd_valid <= 1'b0;
      end
      case (state_r)
        `AFC_ST_RST: begin
          // strobes stay high across the init release edge
          put_strobe_n   <= 1'b1;
          take_pulse_n   <= 1'b1;
          expansion_in_n <= mode_r;
          first_rewind_n <= mode_r ? lead_pat : {NDEV{1'b1}};
          if (cnt_r == 8'h00) begin
            init_n  <= 1'b1;
            cnt_r   <= SET_CYC - 8'h01;
            state_r <= `AFC_ST_WAIT;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        `AFC_ST_WAIT: begin
          // recovery and flag settling after any strobe
          if (cnt_r == 8'h00) begin
            state_r <= `AFC_ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        `AFC_ST_IDLE: begin
          if (init_pend_r) begin
            mode_r  <= depth_mode;
            init_n  <= 1'b0;
            cnt_r   <= RST_CYC - 8'h01;
            state_r <= `AFC_ST_RST;
          end else if (take_rw) begin
            first_rewind_n <= {NDEV{1'b0}};
            cnt_r          <= RET_CYC - 8'h01;
            state_r        <= `AFC_ST_RWLO;
          end else if (go_rd) begin
            take_pulse_n <= 1'b0;
            last_rd_r    <= 1'b1;
            cnt_r        <= RLO_CYC - 8'h01;
            state_r      <= `AFC_ST_RLO;
          end else if (can_wr) begin
            // data set at the fall, long before the storing rise
            in_bus       <= buf_data;
            pop_r        <= 1'b1;
            put_strobe_n <= 1'b0;
            last_rd_r    <= 1'b0;
            cnt_r        <= WLO_CYC - 8'h01;
            state_r      <= `AFC_ST_WLO;
          end
        end
        `AFC_ST_WLO: begin
          if (cnt_r == 8'h00) begin
            put_strobe_n <= 1'b1;
            cnt_r        <= SET_CYC - 8'h01;
            state_r      <= `AFC_ST_WAIT;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        `AFC_ST_RLO: begin
          if (cnt_r == 8'h00) begin
            // sampled while take is low, so flow-through words count too
            rd_data      <= out_s2_r;
            rd_valid     <= 1'b1;
            take_pulse_n <= 1'b1;
            cnt_r        <= SET_CYC - 8'h01;
            state_r      <= `AFC_ST_WAIT;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        `AFC_ST_RWLO: begin
          if (cnt_r == 8'h00) begin
            first_rewind_n <= {NDEV{1'b1}};
            cnt_r          <= SET_CYC - 8'h01;
            state_r        <= `AFC_ST_WAIT;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        default: begin
          state_r <= `AFC_ST_RST;
          init_n  <= 1'b0;
          cnt_r   <= RST_CYC - 8'h01;
        end
      endcase
    end
  end

endmodule // afc_ctrl

// ### afc_ctrl_assertions.sv
// afc_ctrl_assertions.sv: pin-level checks on the queue controller
// assumes: bound to afc_ctrl, device flags arrive asynchronously
module afc_chk #(
  parameter DW   = 9,
  parameter NDEV = 1
) (
  input wire logic            sys_clk,
  input wire logic            rst_n,
  input wire logic            put_strobe_n,
  input wire logic            take_pulse_n,
  input wire logic            init_n,
  input wire logic [NDEV-1:0] first_rewind_n,
  input wire logic            expansion_in_n,
  input wire logic [DW-1:0]   in_bus,
  input wire logic [NDEV-1:0] no_room_flag_n,
  input wire logic [NDEV-1:0] no_data_flag_n,
  input wire logic            half_full,
  input wire logic            dev_full
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // strobe, strap and flag relations
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_init_quiet; $rose(init_n) |-> put_strobe_n && take_pulse_n; endproperty
  a_init_quiet: assert property (p_init_quiet) else $error("strobe low at init release");
  property p_put_room; $fell(put_strobe_n) |-> no_room_flag_n != '0; endproperty
  a_put_room: assert property (p_put_room) else $error("write strobe into full queue");
  property p_put_width; $fell(put_strobe_n) |-> !put_strobe_n [*5] ##1 put_strobe_n; endproperty
  a_put_width: assert property (p_put_width) else $error("write strobe width wrong");
  property p_take_data; $fell(take_pulse_n) |-> $past(no_data_flag_n) != '0; endproperty
  a_take_data: assert property (p_take_data) else $error("read strobe on empty queue");
  property p_take_width; $fell(take_pulse_n) |-> !take_pulse_n [*7] ##1 take_pulse_n; endproperty
  a_take_width: assert property (p_take_width) else $error("read strobe width wrong");
  property p_init_width; $fell(init_n) |-> !init_n [*5] ##1 init_n; endproperty
  a_init_width: assert property (p_init_width) else $error("init pulse width wrong");
  property p_hold_bus; $rose(put_strobe_n) |-> $stable(in_bus); endproperty
  a_hold_bus: assert property (p_hold_bus) else $error("write data moved in strobe");
  property p_depth_quiet; expansion_in_n |-> !half_full && !first_rewind_n[0]; endproperty
  a_depth_quiet: assert property (p_depth_quiet) else $error("depth straps wrong");
  property p_full_flag; $rose(dev_full) |-> $past(no_room_flag_n, 2) == '0; endproperty
  a_full_flag: assert property (p_full_flag) else $error("full without device full");
endmodule // afc_chk

bind afc_ctrl afc_chk #(.DW(DW), .NDEV(NDEV)) u_chk (.sys_clk, .rst_n, .put_strobe_n,
  .take_pulse_n, .init_n, .first_rewind_n, .expansion_in_n, .in_bus, .no_room_flag_n,
  .no_data_flag_n, .half_full, .dev_full);

// ### afc_ctrl_tb.sv
// afc_ctrl_tb.sv: self-checking bench for the queue controller
// assumes: one device model on the pins, words read back in order
module afc_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       wr_valid = 1'b0;
  logic       rd_ready = 1'b0;
  logic       init_req = 1'b0;
  logic       rewind_req = 1'b0;
  logic       depth_mode = 1'b0;
  logic [8:0] wr_data = 9'h000;
  logic [8:0] rd_data, in_bus, out_bus, lfsr;
  logic       wr_ready, rd_valid, busy, dev_full, dev_empty, half_full;
  logic       put_strobe_n, take_pulse_n, init_n, rewind_n, expansion_in_n;
  logic       no_room, no_data, mid_n;
  logic [8:0] exp_q[$];
  logic [8:0] again[$];
  int         failures = 0;
  int         compares = 0;
  int         n;
  always #2.5 sys_clk = ~sys_clk;
  afc_ctrl dut (.sys_clk, .rst_n, .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_ready,
    .rd_data, .init_req, .rewind_req, .depth_mode, .busy, .dev_full, .dev_empty,
    .half_full, .put_strobe_n, .take_pulse_n, .init_n, .first_rewind_n(rewind_n),
    .expansion_in_n, .in_bus, .out_bus, .no_room_flag_n(no_room),
    .no_data_flag_n(no_data), .midpoint_flag_n(mid_n));
  afc_dev_model #(.CAP(16)) u_dev (.put_strobe_n, .take_pulse_n, .init_n, .rewind_n,
    .chain_out_n(),
    .expansion_in_n, .in_bus, .out_bus, .no_room_flag_n(no_room),
    .no_data_flag_n(no_data), .midpoint_flag_n(mid_n));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [8:0] next_rand(logic [8:0] s);
    return {s[7:0], s[8] ^ s[4]};
  endfunction
  task automatic check(string what, logic [8:0] exp, logic [8:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // offers words back to back; a refused word is never noted
  task automatic put_words(int cnt);
    logic ok;
    for (int i = 0; i < cnt; i++) begin
      lfsr = next_rand(lfsr);
      wr_valid <= 1'b1;
      wr_data  <= lfsr;
      n = 0;
      do begin
        #1 ok = wr_ready;
        @(posedge sys_clk);
      end while (ok !== 1'b1 && ++n < 300);
      if (ok === 1'b1) exp_q.push_back(lfsr);
    end
    wr_valid <= 1'b0;
  endtask
  task automatic drain();
    rd_ready <= 1'b1;
    n = 0;
    while (exp_q.size() > 0 && n++ < 5000) @(posedge sys_clk);
    check("words left", 9'h000, 9'(exp_q.size()));
    rd_ready <= 1'b0;
  endtask
  task automatic do_init(logic mode);
    depth_mode <= mode;
    init_req   <= 1'b1;
    @(posedge sys_clk);
    init_req <= 1'b0;
    repeat (40) @(posedge sys_clk);
  endtask
  // scoreboard: each word handed over must be the oldest noted one
  always @(posedge sys_clk) begin
    if (rd_valid === 1'b1 && rd_ready === 1'b1)
      check("read word", exp_q.size() ? exp_q.pop_front() : 9'hXXX, rd_data);
  end
  // hang guard, far beyond the few thousand cycles the tests need
  initial begin
    #200us;
    failures++;
    $display("watchdog expired");
    report_and_stop();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    lfsr = 9'h01C;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (30) @(posedge sys_clk);
    check("init pin", 9'h001, init_n);
    check("empty", 9'h001, dev_empty);
    check("full", 9'h000, dev_full);
    check("standalone strap", 9'h000, expansion_in_n);
    check("busy", 9'h000, busy);
    $display("reset test done");
    put_words(30);
    check("wr ready", 9'h000, wr_ready);
    check("full", 9'h001, dev_full);
    check("half", 9'h001, half_full);
    drain();
    $display("fill test done");
    do_init(1'b0);
    put_words(3);
    again = exp_q;
    drain();
    exp_q = again;
    rewind_req <= 1'b1;
    @(posedge sys_clk);
    rewind_req <= 1'b0;
    drain();
    $display("rewind test done");
    do_init(1'b1);
    check("depth strap", 9'h001, expansion_in_n);
    check("first load", 9'h000, rewind_n);
    put_words(12);
    rewind_req <= 1'b1;
    @(posedge sys_clk);
    rewind_req <= 1'b0;
    repeat (300) @(posedge sys_clk);
    check("half in depth", 9'h000, half_full);
    drain();
    $display("depth test done");
    report_and_stop();
  end
endmodule // afc_ctrl_tb

// ### afc_dev_model.sv
// afc_dev_model.sv: behavioural strobe-driven queue on the far side
// assumes: one device, strobes from the controller, no clock
module afc_dev_model #(
  parameter int CAP = 8192
) (
  input  wire logic       put_strobe_n,
  input  wire logic       take_pulse_n,
  input  wire logic       init_n,
  input  wire logic       rewind_n,
  input  wire logic       expansion_in_n,
  input  wire logic [8:0] in_bus,
  output logic      [8:0] out_bus,
  output logic            no_room_flag_n,
  output logic            no_data_flag_n,
  output logic            midpoint_flag_n,
  output logic            chain_out_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] mem [0:CAP-1];
  int         wp = 0;
  int         rp = 0;
  initial out_bus = 9'h000;
  // write side: init wins, full queue ignores the strobe
  always @(negedge init_n or posedge put_strobe_n) begin
    if (!init_n) wp = 0;
    else if (wp - rp < CAP) begin
      mem[wp % CAP] = in_bus;
      wp = wp + 1;
    end
  end
  // read side: rewind only counts when standalone
  always @(negedge init_n or negedge take_pulse_n or negedge rewind_n) begin
    if (!init_n) rp = 0;
    else if (!rewind_n && !expansion_in_n) rp = 0;
    else if (!take_pulse_n && wp != rp) begin
      out_bus <= #20 mem[rp % CAP];
      rp = rp + 1;
    end
  end
  // released bus shows the inverse, never a stale word
  always @(posedge take_pulse_n) out_bus <= #15 ~out_bus;
  assign no_room_flag_n  = !(wp - rp >= CAP);
  assign no_data_flag_n  = (wp != rp);
  assign midpoint_flag_n = !(!expansion_in_n && wp - rp > CAP / 2);
  // chained only: low while a strobe works the last location
  assign chain_out_n = !(expansion_in_n &&
                         ((!put_strobe_n && wp % CAP == CAP - 1) ||
                          (!take_pulse_n && rp % CAP == 0 && rp > 0)));
endmodule // afc_dev_model

// ### afc_map.vh
// afc_map.vh: constants for the strobe-driven 9-bit queue controller
// assumes: includer runs on a 5 ns clock and includes this by bare name
//
// Overview of operation
// - expansion_in_n low selects standalone full-capacity queue
// - first chain device lead select low, others high
// - chain_out_n feeds next device expansion_in_n; afc_ctrl drives expansion_in_n itself, high in depth mode
// - composite full and empty from all devices
// - width expansion shares controls, any flags valid
// - writer strobes only while room flag high
`ifndef AFC_MAP_VH
`define AFC_MAP_VH

// ----------------------------------------------------------------
// clock and device timing, nanoseconds; synchroniser depth in cycles
// ----------------------------------------------------------------
`define AFC_T_CLK_NS   5
`define AFC_T_WPW_NS   25
`define AFC_T_SETUP_NS 15
`define AFC_T_RPW_NS   25
`define AFC_T_ACC_NS   25
`define AFC_T_RST_NS   25
`define AFC_T_RET_NS   25
`define AFC_T_FLAG_NS  35
`define AFC_SYNC_CYC   2

// ----------------------------------------------------------------
// controller states
// ----------------------------------------------------------------
`define AFC_ST_RST  3'h0
`define AFC_ST_WAIT 3'h1
`define AFC_ST_IDLE 3'h2
`define AFC_ST_WLO  3'h3
`define AFC_ST_RLO  3'h4
`define AFC_ST_RWLO 3'h5

// ----------------------------------------------------------------
// buffer shape
// ----------------------------------------------------------------
`define AFC_BUF_DEPTH 8
`define AFC_BUF_AW    3

`endif
